// ===== hdl/gpa_port.sv
// general-purpose ports d, e and f with peripheral pin sharing on e and f and an ahb-lite register slave
//
// Our own choice: register access over AHB-Lite.
`include "gpa_regs.svh"
`timescale 1ns/10ps
module gpa_port (
	// clock and reset
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	// ahb-lite slave
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic      [31:0]               hrdata,
	output logic                           hreadyout,
	output logic                           hresp,
	// pads
	input  wire gpa_pkg::gpa_pins_t        pin_in,
	output gpa_pkg::gpa_pins_t             pin_out,
	output gpa_pkg::gpa_pins_t             pin_oe,
	// peripherals
	input  wire gpa_pkg::gpa_periph_sig_t  periph_out,
	input  wire gpa_pkg::gpa_periph_sig_t  periph_oe,
	output gpa_pkg::gpa_periph_sig_t       periph_in,
	output gpa_pkg::gpa_periph_cfg_t       periph_cfg
);
	import gpa_pkg::*;

	logic [7:0]  port_d_data;
	logic [7:0]  port_e_data;
	logic [6:0]  port_f_data;
	logic [7:0]  port_d_direction;
	logic [7:0]  port_e_direction;
	logic [6:0]  port_f_direction;
	logic [31:0] periph_reg;
	gpa_pins_t   sync1;
	gpa_pins_t   sync2;
	gpa_pins_t   sync3;
	gpa_pins_t   pin_level;
	logic        wr_pend;
	logic [7:0]  wr_idx;
	logic [7:0]  e_claim;
	logic [6:0]  f_claim;
	logic [7:0]  e_alt_out;
	logic [7:0]  e_alt_oe;
	logic [6:0]  f_alt_out;
	logic [6:0]  f_alt_oe;
	logic        ss_used;
	logic [7:0]  next_rdata;
	logic        addr_ok;
	logic        access;

	// latch or pin per bit, shared by all three data reads
	function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] pin);
		port_read = (dir & lat) | (~dir & pin);
	endfunction : port_read

	assign access = hsel & hready & htrans[1];
	assign addr_ok = (haddr[1:0] == 2'h0) & (haddr[31:10] == 22'h0);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// three stages, a change counts once the last two agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			pin_level <= '0;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			sync3 <= sync2;
			if (sync2 == sync3) begin
				pin_level <= sync3;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_idx <= 8'h00;
		end else begin
			wr_pend <= access & hwrite & addr_ok;
			wr_idx <= haddr[9:2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_d_direction <= `GPA_DIR_RESET;
			port_e_direction <= `GPA_DIR_RESET;
			port_f_direction <= 7'(`GPA_DIR_RESET);
			periph_reg <= `GPA_PERIPH_RESET;
		end else if (wr_pend) begin
			if (wr_idx == `GPA_IDX_D_DIR) begin
				port_d_direction <= hwdata[7:0];
			end
			if (wr_idx == `GPA_IDX_E_DIR) begin
				port_e_direction <= hwdata[7:0];
			end
			if (wr_idx == `GPA_IDX_F_DIR) begin
				port_f_direction <= hwdata[6:0];
			end
			if (wr_idx == `GPA_IDX_PERIPH) begin
				periph_reg <= hwdata;
			end
		end
	end

	// writes reach the latch whatever the direction
	always_ff @(posedge hclk) begin
		if (wr_pend && wr_idx == `GPA_IDX_D_DATA) begin
			port_d_data <= hwdata[7:0];
		end
		if (wr_pend && wr_idx == `GPA_IDX_E_DATA) begin
			port_e_data <= hwdata[7:0];
		end
		if (wr_pend && wr_idx == `GPA_IDX_F_DATA) begin
			port_f_data <= hwdata[6:0];
		end
	end

	assign periph_cfg.spi_enable_bit = periph_reg[`GPA_PF_SPI_EN];
	assign periph_cfg.spi_master_select = periph_reg[`GPA_PF_SPI_MSTR];
	assign periph_cfg.mode_fault_enable = periph_reg[`GPA_PF_MODF_EN];
	assign periph_cfg.serial_iface_enable = periph_reg[`GPA_PF_SCI_EN];
	assign periph_cfg.timer_a_active = periph_reg[`GPA_PF_TA_LSB +: `GPA_PF_TA_W];
	assign periph_cfg.timer_b_active = periph_reg[`GPA_PF_TB_LSB +: `GPA_PF_TB_W];

	// slave select released in master mode without fault detect
	assign ss_used = periph_cfg.spi_enable_bit & ~(periph_cfg.spi_master_select & ~periph_cfg.mode_fault_enable);

	always_comb begin
		e_claim = 8'h00;
		e_alt_out = 8'h00;
		e_alt_oe = 8'h00;
		e_claim[7] = periph_cfg.spi_enable_bit;
		e_alt_out[7] = periph_out.spi[3];
		e_alt_oe[7] = periph_cfg.spi_master_select & periph_oe.spi[3];
		// mosi and miso handed to spi
		e_claim[6] = periph_cfg.spi_enable_bit;
		e_claim[5] = periph_cfg.spi_enable_bit;
		e_alt_out[6] = periph_out.spi[2];
		e_alt_oe[6] = periph_oe.spi[2];
		e_alt_out[5] = periph_out.spi[1];
		e_alt_oe[5] = periph_oe.spi[1];
		e_claim[4] = ss_used;
		e_alt_out[4] = 1'b0;
		e_alt_oe[4] = 1'b0;
		// timer a channels 0 and 1
		e_claim[3:2] = periph_cfg.timer_a_active[1:0];
		e_alt_out[3:2] = periph_out.ta[1:0];
		e_alt_oe[3:2] = periph_oe.ta[1:0];
		e_claim[1] = periph_cfg.serial_iface_enable;
		e_alt_oe[1] = 1'b0;
		e_claim[0] = periph_cfg.serial_iface_enable;
		e_alt_out[0] = periph_out.sci[0];
		e_alt_oe[0] = 1'b1;
	end

	always_comb begin
		f_claim = 7'h00;
		f_alt_out = 7'h00;
		f_alt_oe = 7'h00;
		// timer a channels 2 to 5
		f_claim[3:0] = periph_cfg.timer_a_active[5:2];
		f_alt_out[3:0] = periph_out.ta[5:2];
		f_alt_oe[3:0] = periph_oe.ta[5:2];
		f_claim[5:4] = periph_cfg.timer_b_active;
		f_alt_out[5:4] = periph_out.tb;
		f_alt_oe[5:4] = periph_oe.tb;
	end

	assign pin_out.d = port_d_data;
	assign pin_oe.d = port_d_direction;
	// claimed port e pins ignore direction
	assign pin_out.e = (e_claim & e_alt_out) | (~e_claim & port_e_data);
	assign pin_oe.e = (e_claim & e_alt_oe) | (~e_claim & port_e_direction);
	// claimed port f pins ignore direction
	assign pin_out.f = {1'b0, (f_claim & f_alt_out) | (~f_claim & port_f_data)};
	assign pin_oe.f = {1'b0, (f_claim & f_alt_oe) | (~f_claim & port_f_direction)};

	// peripherals see synchronised pin levels
	assign periph_in.spi = pin_level.e[7:4];
	assign periph_in.sci = pin_level.e[1:0];
	assign periph_in.ta = {pin_level.f[3:0], pin_level.e[3:2]};
	assign periph_in.tb = pin_level.f[5:4];

	always_comb begin
		next_rdata = 8'h00;
		unique case (haddr[9:2])
			`GPA_IDX_D_DATA: next_rdata = port_read(port_d_direction, port_d_data, pin_level.d);
			`GPA_IDX_E_DATA: next_rdata = port_read(port_e_direction, port_e_data, pin_level.e);
			`GPA_IDX_F_DATA: next_rdata = port_read({1'b0, port_f_direction}, {1'b0, port_f_data},
				pin_level.f) & `GPA_F_MASK;
			`GPA_IDX_D_DIR: next_rdata = port_d_direction;
			`GPA_IDX_E_DIR: next_rdata = port_e_direction;
			`GPA_IDX_F_DIR: next_rdata = {1'b0, port_f_direction};
			default: next_rdata = 8'h00;
		endcase
	end

	// the control word is wider than a data byte, so it is read separately
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (access && !hwrite) begin
			if (!addr_ok) begin
				hrdata <= 32'h0000_0000;
			end else if (haddr[9:2] == `GPA_IDX_PERIPH) begin
				hrdata <= periph_reg & 32'h0003_3F0F;
			end else begin
				hrdata <= {24'h000000, next_rdata};
			end
		end
	end
endmodule : gpa_port

// ===== hdl/gpa_regs.svh
// register offsets, field positions and reset values of the port block
`ifndef GPA_REGS_SVH
`define GPA_REGS_SVH
`define GPA_IDX_D_DATA     8'h03
`define GPA_IDX_E_DATA     8'h08
`define GPA_IDX_F_DATA     8'h09
`define GPA_IDX_D_DIR      8'h07
`define GPA_IDX_E_DIR      8'h0C
`define GPA_IDX_F_DIR      8'h0D
`define GPA_IDX_PERIPH     8'h10
`define GPA_DIR_RESET      8'h00
`define GPA_PERIPH_RESET   32'h0000_0000
`define GPA_PF_SPI_EN      0
`define GPA_PF_SPI_MSTR    1
`define GPA_PF_MODF_EN     2
`define GPA_PF_SCI_EN      3
`define GPA_PF_TA_LSB      8
`define GPA_PF_TA_W        6
`define GPA_PF_TB_LSB      16
`define GPA_PF_TB_W        2
`define GPA_F_MASK         8'h7F
`endif

// ===== hdl/gpa_pkg.sv
// types shared by the port block
package gpa_pkg;
	typedef struct packed {
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] f;
	} gpa_pins_t;
	typedef struct packed {
		logic       spi_enable_bit;
		logic       spi_master_select;
		logic       mode_fault_enable;
		logic       serial_iface_enable;
		logic [5:0] timer_a_active;
		logic [1:0] timer_b_active;
	} gpa_periph_cfg_t;
	// peripheral side of the shared pins: spi sck,mosi,miso,ss; sci rx,tx; timer a 0..5; timer b 0..1
	typedef struct packed {
		logic [3:0] spi;
		logic [1:0] sci;
		logic [5:0] ta;
		logic [1:0] tb;
	} gpa_periph_sig_t;
endpackage : gpa_pkg

// ===== test/gpa_port_asserts.sv
// checker for pin sharing and reset state of the port block
`timescale 1ns/10ps
module gpa_port_asserts
	import gpa_pkg::*;
(
	// clock and reset
	input wire logic            hclk,
	input wire logic            hresetn,
	// pads and peripherals
	input wire gpa_pins_t       pin_out,
	input wire gpa_pins_t       pin_oe,
	input wire gpa_periph_sig_t periph_out,
	input wire gpa_periph_sig_t periph_oe,
	input wire gpa_periph_cfg_t periph_cfg
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic spi;
	logic mst;
	logic sci;
	assign spi = periph_cfg.spi_enable_bit;
	assign mst = periph_cfg.spi_master_select;
	assign sci = periph_cfg.serial_iface_enable;
	sequence s_rel;
		$rose(hresetn);
	endsequence
	property p_rst;
		s_rel |-> pin_oe == 24'h00_0000;
	endproperty
	a_rst: assert property (p_rst) else $error("pads driven after reset");
	property p_sck;
		spi |-> pin_oe.e[7] == (mst && periph_oe.spi[3]);
	endproperty
	a_sck: assert property (p_sck) else $error("spi clock drive wrong");
	property p_mosi;
		spi |-> pin_oe.e[6:5] == periph_oe.spi[2:1] && pin_out.e[6:5] == periph_out.spi[2:1];
	endproperty
	a_mosi: assert property (p_mosi) else $error("spi data pins wrong");
	property p_ss;
		spi && (!mst || periph_cfg.mode_fault_enable) |-> !pin_oe.e[4];
	endproperty
	a_ss: assert property (p_ss) else $error("slave select driven");
	property p_ta;
		((pin_oe.e[3:2] ^ periph_oe.ta[1:0]) & periph_cfg.timer_a_active[1:0]) == 2'h0
		&& ((pin_oe.f[3:0] ^ periph_oe.ta[5:2]) & periph_cfg.timer_a_active[5:2]) == 4'h0;
	endproperty
	a_ta: assert property (p_ta) else $error("timer a pin drive wrong");
	property p_tb;
		((pin_oe.f[5:4] ^ periph_oe.tb) & periph_cfg.timer_b_active) == 2'h0;
	endproperty
	a_tb: assert property (p_tb) else $error("timer b pin drive wrong");
	property p_rx;
		sci |-> !pin_oe.e[1];
	endproperty
	a_rx: assert property (p_rx) else $error("serial input driven");
	property p_tx;
		sci |-> pin_oe.e[0] && pin_out.e[0] == periph_out.sci[0];
	endproperty
	a_tx: assert property (p_tx) else $error("serial output wrong");
endmodule : gpa_port_asserts
bind gpa_port gpa_port_asserts gpa_port_asserts_inst (.hclk(hclk), .hresetn(hresetn), .pin_out(pin_out),
	.pin_oe(pin_oe), .periph_out(periph_out), .periph_oe(periph_oe), .periph_cfg(periph_cfg));

// ===== test/gpa_pads.sv
// board pads: each pin reads its own drive or the board level
`timescale 1ns/10ps
module gpa_pads
	import gpa_pkg::*;
(
	// chip side
	input wire gpa_pins_t pin_out,
	input wire gpa_pins_t pin_oe,
	output gpa_pins_t     pin_in,
	// board side
	input wire gpa_pins_t ext_level
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gpa_pads

// ===== test/testbench.sv
// self-checking bench for the port block
`timescale 1ns/10ps
`include "gpa_regs.svh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", nm, e, a); end end
module testbench;
	import gpa_pkg::*;
	logic            hclk, hresetn, hsel, hwrite, hrdy, hresp;
	logic [31:0]     haddr, hwdata, hrdata;
	logic [1:0]      htrans;
	logic [2:0]      hsize;
	gpa_pins_t       pin_in, pin_out, pin_oe, ext;
	gpa_periph_sig_t p_out, p_oe, p_in;
	int              bad_count, n_checks;
	logic [7:0]      di[3] = '{`GPA_IDX_D_DIR, `GPA_IDX_E_DIR, `GPA_IDX_F_DIR};
	logic [7:0]      da[3] = '{`GPA_IDX_D_DATA, `GPA_IDX_E_DATA, `GPA_IDX_F_DATA};
	logic [7:0]      mk[3] = '{8'hFF, 8'hFF, 8'h7F};
	gpa_port gpa_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
		.hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(p_out),
		.periph_oe(p_oe), .periph_in(p_in), .periph_cfg());
	gpa_pads gpa_pads_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .ext_level(ext));
	always #2.5 hclk = ~hclk;
	function automatic logic [7:0] pb(gpa_pins_t s, int p);
		return s[23 - 8 * p -: 8];
	endfunction : pb
	task automatic wait_rdy;
		do @(posedge hclk); while (hrdy !== 1'b1);
	endtask : wait_rdy
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : xfer
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		xfer(1'b1, idx, wd, d);
		// write lands at the data-phase edge; one idle edge so a following read sees it
		@(posedge hclk);
	endtask : wr
	task automatic chk_rd(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		xfer(1'b0, idx, 32'h0, d);
		`CHK($sformatf("reg %h", idx), exp, d)
	endtask : chk_rd
	task automatic wrap_up;
		if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		#20000;
		bad_count++;
		wrap_up();
	end
	initial begin
		{hclk, hresetn, hsel, hwrite, haddr, hwdata, htrans, bad_count, n_checks} = '0;
		hsize = 3'h2;
		p_out = '0;
		p_oe = '0;
		ext = 24'h5A_C3_96;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int p = 0; p < 3; p++) begin
			chk_rd(di[p], 32'h0);
			wr(da[p], 32'hA5);
			repeat (6) @(posedge hclk);
			chk_rd(da[p], {24'h0, pb(ext, p) & mk[p]});
			wr(di[p], {24'h0, 8'hF0 & mk[p]});
			repeat (6) @(posedge hclk);
			chk_rd(da[p], {24'h0, (8'hA0 | pb(ext, p) & 8'h0F) & mk[p]});
			`CHK("oe", 8'hF0 & mk[p], pb(pin_oe, p))
			`CHK("out", 8'hA0 & mk[p], pb(pin_out, p) & 8'hF0)
		end
		// second reset must leave data latches alone
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_rd(`GPA_IDX_F_DIR, 32'h0);
		wr(`GPA_IDX_F_DIR, 32'h7F);
		chk_rd(`GPA_IDX_F_DATA, 32'h25);
		p_oe <= '1;
		p_out <= '1;
		wr(`GPA_IDX_F_DIR, 32'h0);
		wr(`GPA_IDX_E_DIR, 32'h0);
		wr(`GPA_IDX_PERIPH, 32'h0003_3F0B);
		chk_rd(`GPA_IDX_PERIPH, 32'h0003_3F0B);
		repeat (6) @(posedge hclk);
		`CHK("oe e", 8'hED, pin_oe.e)
		`CHK("oe f", 8'h3F, pin_oe.f)
		`CHK("rx", ext.e[1], p_in.sci[1])
		chk_rd(`GPA_IDX_F_DATA, {24'h0, 8'h3F | ext.f & 8'h40});
		chk_rd(`GPA_IDX_E_DATA, {24'h0, 8'hED | ext.e & 8'h12});
		wr(`GPA_IDX_E_DIR, 32'hFF);
		wr(`GPA_IDX_PERIPH, 32'h0000_0009);
		@(posedge hclk);
		`CHK("oe slave", 8'h6D, pin_oe.e)
		chk_rd(`GPA_IDX_E_DATA, 32'hA5);
		chk_rd(8'h20, 32'h0);
		wrap_up();
	end
endmodule : testbench
